// [logic/byte_packer_consts.vh]
// Constants of the serial byte packet packer: register map, fields, codes.
// Assumes inclusion by bare name from the packer design files.
//
// Operation
// - Four marker policies: plain, one extra byte, two extra bytes, strip; plain default.
// - Policy has no effect while the first marker is disabled.
// - Plain policy flushes on marker and keeps marker bytes in the packet.
// - One-extra policy flushes after exactly one more byte, that byte included.
// - Two-extra policy flushes after exactly two more bytes, those included.
// - Strip policy flushes on marker but drops the matched marker bytes.
// - Idle flush time 0 to 65535 ms, default 0; zero disables idle flushing.
// - Nonzero idle time flushes the buffer after that many idle milliseconds.
// - Flush length 0, default, disables length flushing; markers, idle or full only.
// - Flush length 1 to 1024 flushes when the byte count reaches it.
// - Each marker has an enable, default off, and an eight-bit match value.
// - First marker alone matches one byte; both match first then second byte.
// - With markers on, bytes accumulate until marker seen, buffer full, flush length reached or idle time out.
`ifndef BYTE_PACKER_CONSTS_VH
`define BYTE_PACKER_CONSTS_VH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_MARK      8'h04
`define OFS_FLUSH_LEN 8'h08
`define OFS_IDLE_MS   8'h0c
`define OFS_STATUS    8'h10
`define OFS_PKT_CNT   8'h14

// Control fields
`define CTRL_M1_EN    0
`define CTRL_M2_EN    1
`define CTRL_POL_LO   2
`define CTRL_POL_HI   3
`define CTRL_SRST     31

// Marker value fields
`define MARK1_LO      0
`define MARK1_HI      7
`define MARK2_LO      8
`define MARK2_HI      15

// Status fields
`define STAT_EXTRA_LO 11
`define STAT_EXTRA_HI 12
`define STAT_BUSY     13

// Marker policies
`define POL_PLAIN     2'h0
`define POL_PLUS1     2'h1
`define POL_PLUS2     2'h2
`define POL_STRIP     2'h3

// Reset values
`define RST_POL       2'h0
`define RST_MARK      8'h00
`define RST_LEN       11'h000
`define RST_IDLE      16'h0000

// Engine states
`define ST_ACCEPT     1'b0
`define ST_DRAIN      1'b1

// Holding counts and extra-byte counts
`define HELD_NONE     2'h0
`define HELD_ONE      2'h1
`define HELD_TWO      2'h2
`define EXTRA_NONE    2'h0
`define EXTRA_ONE     2'h1
`define EXTRA_TWO     2'h2

`endif

// [logic/pair_buffer.v]
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset; clr_in empties it.
module pair_buffer #(
  parameter W = 9
) (
  input  wire         core_clk_in,   // System clock
  input  wire         resetn_in,     // Async reset, active low
  input  wire         clr_in,        // Sync empty
  input  wire [W-1:0] in_data_in,    // Fill data
  input  wire         in_valid_in,   // Fill valid
  output wire         in_ready_out,  // Room for a word
  output wire [W-1:0] out_data_out,  // Head word
  output wire         out_valid_out, // Head valid
  input  wire         out_ready_in   // Drain ready
);
  reg [W-1:0] head_ff;
  reg [W-1:0] tail_ff;
  reg         head_v_ff;
  reg         tail_v_ff;
  wire        push;
  wire        pop;

  // Handshakes
  assign push          = in_valid_in & ~tail_v_ff;
  assign pop           = head_v_ff & out_ready_in;
  assign in_ready_out  = ~tail_v_ff;
  assign out_data_out  = head_ff;
  assign out_valid_out = head_v_ff;

  // Entry update
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      head_ff   <= {W{1'b0}};
      tail_ff   <= {W{1'b0}};
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
    end else if (clr_in) begin
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
    end else if (pop) begin
      if (tail_v_ff) begin
        head_ff   <= tail_ff;
        tail_v_ff <= 1'b0;
      end else begin
        head_ff   <= in_data_in;
        head_v_ff <= push;
      end
    end else if (push) begin
      if (!head_v_ff) begin
        head_ff   <= in_data_in;
        head_v_ff <= 1'b1;
      end else begin
        tail_ff   <= in_data_in;
        tail_v_ff <= 1'b1;
      end
    end
  end
endmodule

// [logic/byte_packer.v]
// Serial byte packet packer: collects received bytes into packets.
// Assumes an APB master, a byte source, a packet sink and a 1 ms tick pulse.
`include "byte_packer_consts.vh"

module byte_packer #(
  parameter DEPTH = 1024, // Packet buffer capacity in bytes
  parameter CW    = 11    // Byte count width
) (
  input  wire        core_clk_in,    // 40 MHz clock
  input  wire        resetn_in,      // Async reset, active low
  input  wire        psel_in,        // APB select
  input  wire        penable_in,     // APB enable
  input  wire        pwrite_in,      // APB write
  input  wire [7:0]  paddr_in,       // APB byte address
  input  wire [31:0] pwdata_in,      // APB write data
  output reg  [31:0] prdata_out,     // APB read data
  output reg         pready_out,     // APB ready
  output reg         pslverr_out,    // APB error, unmapped
  input  wire        ms_tick_in,     // One pulse per millisecond
  input  wire [7:0]  byte_data_in,   // Received byte
  input  wire        byte_valid_in,  // Byte valid
  output reg         byte_ready_out, // Byte taken when high
  output wire [7:0]  pkt_data_out,   // Packet byte
  output wire        pkt_last_out,   // Final byte of packet
  output wire        pkt_valid_out,  // Packet byte valid
  input  wire        pkt_ready_in    // Sink ready
);
  // Configuration
  reg          m1_en_ff;
  reg          m2_en_ff;
  reg  [1:0]   pol_ff;
  reg  [7:0]   mark1_ff;
  reg  [7:0]   mark2_ff;
  reg  [CW-1:0] flen_ff;
  reg  [15:0]  idle_ms_ff;
  reg          srst_ff;
  // Engine state
  reg          state_ff;
  reg  [CW-1:0] cnt_ff;
  reg  [1:0]   held_ff;
  reg  [7:0]   h_old_ff;
  reg  [7:0]   h_new_ff;
  reg          hit_ff;
  reg  [1:0]   extra_ff;
  reg  [15:0]  idle_cnt_ff;
  reg  [23:0]  q_ff;
  reg  [1:0]   qn_ff;
  reg          q_last_ff;
  reg  [15:0]  pkts_ff;
  // Next values
  reg          nxt_state;
  reg  [CW-1:0] nxt_cnt;
  reg  [1:0]   nxt_held;
  reg  [7:0]   nxt_h_old;
  reg  [7:0]   nxt_h_new;
  reg          nxt_hit;
  reg  [1:0]   nxt_extra;
  reg  [23:0]  nxt_q;
  reg  [1:0]   nxt_qn;
  reg          nxt_q_last;
  reg  [31:0]  nxt_rdata;
  reg          nxt_err;
  // Decode
  wire         acc;
  wire         two;
  wire         det;
  wire         len_hit;
  wire         full;
  wire         extra_done;
  wire         strip;
  wire         plain;
  wire         flush;
  wire         idle_fire;
  wire         drain_push;
  wire         fifo_ready;
  wire         setup_acc;
  wire         wr_en;
  wire         mapped;
  wire [CW-1:0] cnt_inc;

  // Byte lanes of the tail of a held sequence, first byte on top
  function [23:0] take_tail;
    input [23:0] seq;
    input [1:0]  n;
    begin
      case (n)
        2'h1:    take_tail = {seq[7:0], 16'h0000};
        2'h2:    take_tail = {seq[15:0], 8'h00};
        default: take_tail = seq;
      endcase
    end
  endfunction

  // APB decode; one wait state per access
  assign setup_acc = psel_in & penable_in & ~pready_out;
  assign wr_en     = psel_in & penable_in & pready_out & pwrite_in;
  assign mapped    = (paddr_in == `OFS_CTRL) | (paddr_in == `OFS_MARK) |
                     (paddr_in == `OFS_FLUSH_LEN) | (paddr_in == `OFS_IDLE_MS) |
                     (paddr_in == `OFS_STATUS) | (paddr_in == `OFS_PKT_CNT);

  // Byte acceptance and match terms
  assign acc     = byte_valid_in & byte_ready_out;
  assign cnt_inc = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
  assign two     = m1_en_ff & m2_en_ff;
  assign det     = m1_en_ff & (extra_ff == `EXTRA_NONE) &
                   (two ? (hit_ff & (byte_data_in == mark2_ff)) : (byte_data_in == mark1_ff));
  assign len_hit = (flen_ff != `RST_LEN) & (cnt_inc == flen_ff);
  assign full    = (cnt_inc == DEPTH[CW-1:0]);
  assign extra_done = (extra_ff == `EXTRA_ONE);
  assign plain   = det & (pol_ff == `POL_PLAIN);
  assign strip   = det & (pol_ff == `POL_STRIP);
  assign flush   = plain | strip | extra_done | len_hit | full;
  assign idle_fire = (state_ff == `ST_ACCEPT) & ~acc & (idle_ms_ff != `RST_IDLE) &
                     (cnt_ff != `RST_LEN) & (idle_cnt_ff >= idle_ms_ff);
  assign drain_push = (state_ff == `ST_DRAIN) & fifo_ready;

  // Packer engine next state
  always @* begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_held   = held_ff;
    nxt_h_old  = h_old_ff;
    nxt_h_new  = h_new_ff;
    nxt_hit    = hit_ff;
    nxt_extra  = extra_ff;
    nxt_q      = q_ff;
    nxt_qn     = qn_ff;
    nxt_q_last = q_last_ff;
    if (acc) begin
      nxt_q_last = flush;
      if (flush) begin
        nxt_cnt   = `RST_LEN;
        nxt_held  = `HELD_NONE;
        nxt_hit   = 1'b0;
        nxt_extra = `EXTRA_NONE;
        if (strip & two) begin
          nxt_q  = {h_old_ff, 16'h0000};
          nxt_qn = (held_ff == `HELD_TWO) ? `HELD_ONE : `HELD_NONE;
        end else if (strip) begin
          nxt_q  = take_tail({8'h00, h_old_ff, h_new_ff}, held_ff);
          nxt_qn = held_ff;
        end else begin
          nxt_q  = take_tail({h_old_ff, h_new_ff, byte_data_in}, held_ff + `HELD_ONE);
          nxt_qn = held_ff + `HELD_ONE;
        end
      end else begin
        nxt_cnt   = cnt_inc;
        nxt_h_old = h_new_ff;
        nxt_h_new = byte_data_in;
        nxt_held  = (held_ff == `HELD_TWO) ? `HELD_TWO : held_ff + `HELD_ONE;
        nxt_q     = {h_old_ff, 16'h0000};
        nxt_qn    = (held_ff == `HELD_TWO) ? `HELD_ONE : `HELD_NONE;
        nxt_hit   = two & (extra_ff == `EXTRA_NONE) & (byte_data_in == mark1_ff) & ~det;
        if (det & (pol_ff == `POL_PLUS1)) begin
          nxt_extra = `EXTRA_ONE;
        end else if (det & (pol_ff == `POL_PLUS2)) begin
          nxt_extra = `EXTRA_TWO;
        end else if (extra_ff != `EXTRA_NONE) begin
          nxt_extra = extra_ff - `EXTRA_ONE;
        end
      end
      nxt_state = (nxt_qn != `HELD_NONE) ? `ST_DRAIN : `ST_ACCEPT;
    end else if (idle_fire) begin
      nxt_q      = take_tail({8'h00, h_old_ff, h_new_ff}, held_ff);
      nxt_qn     = held_ff;
      nxt_q_last = 1'b1;
      nxt_cnt    = `RST_LEN;
      nxt_held   = `HELD_NONE;
      nxt_hit    = 1'b0;
      nxt_extra  = `EXTRA_NONE;
      nxt_state  = `ST_DRAIN;
    end else if (drain_push) begin
      nxt_q     = {q_ff[15:0], 8'h00};
      nxt_qn    = qn_ff - `HELD_ONE;
      nxt_state = (qn_ff == `HELD_ONE) ? `ST_ACCEPT : `ST_DRAIN;
    end
  end

  // Engine registers
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff       <= `ST_ACCEPT;
      cnt_ff         <= `RST_LEN;
      held_ff        <= `HELD_NONE;
      h_old_ff       <= 8'h00;
      h_new_ff       <= 8'h00;
      hit_ff         <= 1'b0;
      extra_ff       <= `EXTRA_NONE;
      idle_cnt_ff    <= 16'h0000;
      q_ff           <= 24'h000000;
      qn_ff          <= `HELD_NONE;
      q_last_ff      <= 1'b0;
      pkts_ff        <= 16'h0000;
      byte_ready_out <= 1'b0;
    end else if (srst_ff) begin
      state_ff       <= `ST_ACCEPT;
      cnt_ff         <= `RST_LEN;
      held_ff        <= `HELD_NONE;
      hit_ff         <= 1'b0;
      extra_ff       <= `EXTRA_NONE;
      idle_cnt_ff    <= 16'h0000;
      qn_ff          <= `HELD_NONE;
      byte_ready_out <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      cnt_ff         <= nxt_cnt;
      held_ff        <= nxt_held;
      h_old_ff       <= nxt_h_old;
      h_new_ff       <= nxt_h_new;
      hit_ff         <= nxt_hit;
      extra_ff       <= nxt_extra;
      q_ff           <= nxt_q;
      qn_ff          <= nxt_qn;
      q_last_ff      <= nxt_q_last;
      // refuse bytes while soft reset lands
      byte_ready_out <= (nxt_state == `ST_ACCEPT) & ~(wr_en & (paddr_in == `OFS_CTRL) & pwdata_in[`CTRL_SRST]);
      if ((acc & flush) | idle_fire) begin
        pkts_ff <= pkts_ff + 16'h0001;
      end
      if (acc) begin
        idle_cnt_ff <= 16'h0000;
      end else if (ms_tick_in & (cnt_ff != `RST_LEN) & (idle_cnt_ff != 16'hffff)) begin
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      end
    end
  end

  // Read data and error for the access phase
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err   = ~mapped;
    case (paddr_in)
      `OFS_CTRL: begin
        nxt_rdata[`CTRL_M1_EN]                = m1_en_ff;
        nxt_rdata[`CTRL_M2_EN]                = m2_en_ff;
        nxt_rdata[`CTRL_POL_HI:`CTRL_POL_LO]  = pol_ff;
      end
      `OFS_MARK: begin
        nxt_rdata[`MARK1_HI:`MARK1_LO] = mark1_ff;
        nxt_rdata[`MARK2_HI:`MARK2_LO] = mark2_ff;
      end
      `OFS_FLUSH_LEN: nxt_rdata[CW-1:0] = flen_ff;
      `OFS_IDLE_MS:   nxt_rdata[15:0]   = idle_ms_ff;
      `OFS_STATUS: begin
        nxt_rdata[CW-1:0]                          = cnt_ff;
        nxt_rdata[`STAT_EXTRA_HI:`STAT_EXTRA_LO]   = extra_ff;
        nxt_rdata[`STAT_BUSY]                      = state_ff;
      end
      `OFS_PKT_CNT:   nxt_rdata[15:0]   = pkts_ff;
      default:        nxt_rdata         = 32'h00000000;
    endcase
  end

  // APB slave registers
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
      m1_en_ff    <= 1'b0;
      m2_en_ff    <= 1'b0;
      pol_ff      <= `RST_POL;
      mark1_ff    <= `RST_MARK;
      mark2_ff    <= `RST_MARK;
      flen_ff     <= `RST_LEN;
      idle_ms_ff  <= `RST_IDLE;
      srst_ff     <= 1'b0;
    end else begin
      pready_out <= setup_acc;
      srst_ff    <= wr_en & (paddr_in == `OFS_CTRL) & pwdata_in[`CTRL_SRST];
      if (setup_acc) begin
        prdata_out  <= pwrite_in ? 32'h00000000 : nxt_rdata;
        pslverr_out <= nxt_err;
      end else begin
        pslverr_out <= 1'b0;
      end
      if (wr_en) begin
        case (paddr_in)
          `OFS_CTRL: begin
            m1_en_ff <= pwdata_in[`CTRL_M1_EN];
            m2_en_ff <= pwdata_in[`CTRL_M2_EN];
            pol_ff   <= pwdata_in[`CTRL_POL_HI:`CTRL_POL_LO];
          end
          `OFS_MARK: begin
            mark1_ff <= pwdata_in[`MARK1_HI:`MARK1_LO];
            mark2_ff <= pwdata_in[`MARK2_HI:`MARK2_LO];
          end
          `OFS_FLUSH_LEN: flen_ff    <= pwdata_in[CW-1:0];
          `OFS_IDLE_MS:   idle_ms_ff <= pwdata_in[15:0];
          default:        srst_ff    <= 1'b0;
        endcase
      end
    end
  end

  // Output buffer absorbs sink stalls
  pair_buffer #(
    .W (9)
  ) u_out_buf (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .clr_in        (srst_ff),
    .in_data_in    ({(qn_ff == `HELD_ONE) & q_last_ff, q_ff[23:16]}),
    .in_valid_in   (state_ff == `ST_DRAIN),
    .in_ready_out  (fifo_ready),
    .out_data_out  ({pkt_last_out, pkt_data_out}),
    .out_valid_out (pkt_valid_out),
    .out_ready_in  (pkt_ready_in)
  );
endmodule

// [dv/byte_packer_sva.sv]
// Port checker for the byte packer: APB timing, output hold, flush causes.
// Assumes binding to byte_packer; configuration mirrored from APB writes.
module byte_packer_sva (
  input wire        core_clk_in,    // Clock
  input wire        resetn_in,      // Reset
  input wire        psel_in,        // Select
  input wire        penable_in,     // Enable
  input wire        pwrite_in,      // Write
  input wire [7:0]  paddr_in,       // Address
  input wire [31:0] pwdata_in,      // Write data
  input wire [31:0] prdata_out,     // Read data
  input wire        pready_out,     // Ready
  input wire        pslverr_out,    // Error
  input wire [7:0]  byte_data_in,   // Byte
  input wire        byte_valid_in,  // Byte valid
  input wire        byte_ready_out, // Byte ready
  input wire [7:0]  pkt_data_out,   // Packet byte
  input wire        pkt_last_out,   // Packet end
  input wire        pkt_valid_out,  // Packet valid
  input wire        pkt_ready_in    // Sink ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  reg  [3:0]  ctrl_ff;
  reg  [10:0] len_ff;
  reg  [7:0]  mk1_ff;
  reg         clr_ff;
  wire        wr_done = psel_in && penable_in && pwrite_in && pready_out;
  wire        take    = byte_valid_in && byte_ready_out;
  // Mirror of the written configuration
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_ff <= 4'h0;
      len_ff  <= 11'h000;
      mk1_ff  <= 8'h00;
      clr_ff  <= 1'b0;
    end else begin
      // Soft reset pulse; output buffer emptied at the next edge
      clr_ff <= wr_done && paddr_in == 8'h00 && pwdata_in[31];
      if (wr_done) begin
        if (paddr_in == 8'h00) ctrl_ff <= pwdata_in[3:0];
        if (paddr_in == 8'h08) len_ff <= pwdata_in[10:0];
        if (paddr_in == 8'h04) mk1_ff <= pwdata_in[7:0];
      end
    end
  end
  property p_rdy_wait;
    psel_in && !penable_in |=> !pready_out ##1 pready_out;
  endproperty
  property p_rdy_pulse;
    pready_out |=> !pready_out;
  endproperty
  property p_unmapped;
    pready_out && paddr_in > 8'h14 |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  property p_hold;
    pkt_valid_out && !pkt_ready_in && !clr_ff |=> pkt_valid_out && $stable(pkt_data_out) && $stable(pkt_last_out);
  endproperty
  property p_len1;
    take && len_ff == 11'h001 && !ctrl_ff[0] |-> ##[1:40] (pkt_valid_out && pkt_last_out);
  endproperty
  property p_mark_plain;
    take && ctrl_ff == 4'h1 && byte_data_in == mk1_ff
      |-> ##[1:40] (pkt_valid_out && pkt_last_out && pkt_data_out == mk1_ff);
  endproperty
  property p_strip;
    ctrl_ff == 4'hd && pkt_valid_out |-> pkt_data_out != mk1_ff;
  endproperty
  property p_srst;
    wr_done && paddr_in == 8'h00 && pwdata_in[31] |-> ##[1:4] !byte_ready_out;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not after one wait state");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_hold: assert property (p_hold) else $error("packet byte changed while stalled");
  a_len1: assert property (p_len1) else $error("length one did not flush");
  a_mark_plain: assert property (p_mark_plain) else $error("marker did not end packet");
  a_strip: assert property (p_strip) else $error("stripped marker seen");
  a_srst: assert property (p_srst) else $error("soft reset had no effect");
  c_len1: cover property (take && len_ff == 11'h001);
  c_stall: cover property (pkt_valid_out && !pkt_ready_in ##1 !byte_ready_out);
  c_strip: cover property (ctrl_ff == 4'hd && pkt_last_out && pkt_valid_out);
  c_srst: cover property (wr_done && pwdata_in[31]);
endmodule

bind byte_packer byte_packer_sva chk_u (.core_clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .byte_data_in, .byte_valid_in,
  .byte_ready_out, .pkt_data_out, .pkt_last_out, .pkt_valid_out, .pkt_ready_in);

// [dv/pkt_sink_model.sv]
// Packet sink model: takes packet bytes with random or forced stalls.
// Assumes the bench seeds $urandom and drives stall_in after clock edges.
module pkt_sink_model (
  input  wire  core_clk_in,  // Clock
  input  wire  resetn_in,    // Reset
  input  wire  stall_in,     // Hold ready low
  output logic pkt_ready_out // Ready to packer
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready drops about one cycle in four, and stays low while stalled
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) pkt_ready_out <= 1'b0;
    else pkt_ready_out <= !stall_in && ($urandom % 4 != 0);
  end
endmodule

// [dv/serial_byte_packet_packer_bench.sv]
// Bench for the byte packer: APB master, byte source, ms tick, sink model.
// Assumes one APB wait state and a buffer depth shortened to eight.
module serial_byte_packet_packer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 8;
  logic        core_clk_in, resetn_in, psel_in, penable_in, pwrite_in, ms_tick_in, byte_valid_in, stall;
  logic        pready_out, pslverr_out, byte_ready_out, pkt_last_out, pkt_valid_out, pkt_ready_in;
  logic [7:0]  paddr_in, byte_data_in, pkt_data_out;
  logic [31:0] pwdata_in, prdata_out;
  logic [32:0] exp_rd[$];
  logic [8:0]  exp_pkt[$];
  logic [31:0] tails[4] = '{32'h0d, 32'h210d, 32'h22210d, 32'h0d};
  int          nts[4] = '{1, 2, 3, 1};
  int          bad_count, samples_checked, cyc;

  byte_packer #(.DEPTH(DEPTH), .CW(11)) dut_u (.core_clk_in, .resetn_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ms_tick_in,
    .byte_data_in, .byte_valid_in, .byte_ready_out, .pkt_data_out, .pkt_last_out, .pkt_valid_out,
    .pkt_ready_in);
  pkt_sink_model sink_u (.core_clk_in, .resetn_in, .stall_in(stall), .pkt_ready_out(pkt_ready_in));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // Millisecond tick every 20 cycles, and the hang limit
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    ms_tick_in <= (cyc % 20 == 19);
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Results against the oldest notes
  always @(posedge core_clk_in) begin
    if (pready_out && psel_in && !pwrite_in)
      chk("read", exp_rd.size() != 0 ? exp_rd.pop_front() : 'x, {pslverr_out, prdata_out});
    if (pkt_valid_out && pkt_ready_in)
      chk("pkt", exp_pkt.size() != 0 ? {24'h0, exp_pkt.pop_front()} : 'x,
          {24'h0, pkt_last_out, pkt_data_out});
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic put(input logic [7:0] b);
    byte_data_in <= b;
    byte_valid_in <= 1'b1;
    do @(posedge core_clk_in); while (byte_ready_out !== 1'b1);
  endtask

  // n random bytes, then nt tail bytes; the last nst of them are stripped
  task automatic pkt(input int n, input logic [31:0] tail, input int nt, input int nst);
    logic [7:0] b[$];
    int         tot;
    repeat (n) b.push_back(8'h10 + 8'($urandom % 96));
    for (int i = 0; i < nt; i++) b.push_back(tail[8*i +: 8]);
    tot = b.size() - nst;
    for (int i = 0; i < tot; i++) exp_pkt.push_back({i == tot - 1, b[i]});
    foreach (b[i]) put(b[i]);
    byte_valid_in <= 1'b0;
    byte_data_in <= ~b[b.size()-1];
    while (exp_pkt.size() != 0) @(posedge core_clk_in);
    repeat (4) @(posedge core_clk_in);
  endtask

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {resetn_in, psel_in, penable_in, pwrite_in, byte_valid_in, stall} = 6'h0;
    {paddr_in, byte_data_in, pwdata_in} = 48'h0;
    void'($urandom(32'hbdb9));
    repeat (6) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    // Reset values, refused address, marker write back
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h08, 33'h0);
    rd(8'h0c, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    apb(1'b1, 8'h04, 32'h0a0d);
    rd(8'h04, 33'h0a0d);
    // Length flushes, the second against a stalled sink
    apb(1'b1, 8'h08, 32'h1);
    pkt(1, 0, 0, 0);
    apb(1'b1, 8'h08, 32'h6);
    fork
      pkt(6, 0, 0, 0);
      begin
        stall <= 1'b1;
        repeat (80) @(posedge core_clk_in);
        stall <= 1'b0;
      end
    join
    // Policy ignored while the first marker is off
    apb(1'b1, 8'h00, 32'hc);
    apb(1'b1, 8'h08, 32'h3);
    pkt(2, 32'h0d, 1, 0);
    apb(1'b1, 8'h08, 32'h0);
    // Single marker under each policy; sender supplies markers
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 8'h00, {28'h0, 2'(p), 2'b01});
      pkt(3, tails[p], nts[p], int'(p == 3));
    end
    pkt(DEPTH, 0, 0, 0);
    // Two-byte marker: broken match, then restart on repeated first value
    apb(1'b1, 8'h00, 32'h3);
    pkt(2, 32'h0a0d310d, 4, 0);
    apb(1'b1, 8'h00, 32'hf);
    pkt(2, 32'h0a0d0d, 3, 2);
    // Idle flush after three quiet ticks, then idle flushing off
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'h3);
    pkt(2, 0, 0, 0);
    apb(1'b1, 8'h0c, 32'h0);
    put(8'h55);
    put(8'h56);
    byte_valid_in <= 1'b0;
    byte_data_in <= 8'ha9;
    repeat (300) @(posedge core_clk_in);
    rd(8'h10, 33'h2);
    // Soft reset drops the held bytes before a length flush
    apb(1'b1, 8'h00, 32'h80000000);
    rd(8'h10, 33'h0);
    apb(1'b1, 8'h08, 32'h3);
    pkt(3, 0, 0, 0);
    // Twelve flushes so far; soft reset keeps the count
    rd(8'h14, 33'hc);
    stop_test();
  end
endmodule
